//--- psa_defines.svh
// register indices, field positions and reset values of the protection alarm event block
`ifndef PSA_DEFINES_SVH
`define PSA_DEFINES_SVH

// ----------------------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------------------
`define PSA_IDX_FLAGS    8'h42
`define PSA_IDX_ENABLE   8'h43
`define PSA_IDX_MASK     8'h44
`define PSA_IDX_LIVE     8'h45

// ----------------------------------------------------------------------------
// field positions and layouts
// ----------------------------------------------------------------------------
`define PSA_BIT_SIGDEG   0
`define PSA_BIT_SIGFAIL  1
`define PSA_BIT_SWBYTE   4
`define PSA_FLAG_MASK    8'h13
`define PSA_DUAL_MASK    8'h03

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define PSA_FLAGS_RESET  8'h00
`define PSA_ENABLE_RESET 8'h00
`define PSA_MASK_RESET   8'h00
`define PSA_DATA_RESET   32'h0000_0000

`endif

//--- psa_event_detect.sv
// per-bit transition detector for enabled alarm status signals
`timescale 1ns/1ns
`include "psa_defines.svh"
module psa_event_detect
    import psa_pkg::*;
#(
    parameter int         WIDTH     = 8,
    parameter logic [7:0] DUAL_MASK = `PSA_DUAL_MASK
)
(
    input  wire logic             clock,
    input  wire logic             resetSync_n,
    input  wire logic [WIDTH-1:0] statusIn,
    input  wire logic [WIDTH-1:0] enableIn,
    output logic      [WIDTH-1:0] eventOut,
    output logic                  armed
);

    psa_edge_state_t s_reg;
    psa_edge_state_t s_next;

    // ------------------------------------------------------------------------
    // edge classification
    // ------------------------------------------------------------------------
    // nothing fires until one sample is held, so a level present at reset
    // release is not taken for a transition
    for (genvar b = 0; b < WIDTH; b++) begin : g_bit
        if (DUAL_MASK[b]) begin : g_dual
            assign eventOut[b] = s_reg.armed && enableIn[b] && (statusIn[b] ^ s_reg.prev[b]);
        end else begin : g_single
            assign eventOut[b] = s_reg.armed && enableIn[b] && statusIn[b] && !s_reg.prev[b];
        end
    end

    always_comb begin
        s_next       = s_reg;
        s_next.prev  = 8'(statusIn);
        s_next.armed = 1'b1;
    end

    always_ff @(posedge clock or negedge resetSync_n) begin
        if (!resetSync_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign armed = s_reg.armed;

endmodule : psa_event_detect

//--- psa_pkg.sv
// types shared by the protection alarm event block
package psa_pkg;

    // ------------------------------------------------------------------------
    // register selection
    // ------------------------------------------------------------------------
    typedef enum {
        PSA_SEL_NONE,
        PSA_SEL_FLAGS,
        PSA_SEL_ENABLE,
        PSA_SEL_MASK,
        PSA_SEL_LIVE
    } psa_reg_sel_t;

    // ------------------------------------------------------------------------
    // state of the top module
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  flags;
        logic [7:0]  enable;
        logic [7:0]  mask;
        logic [31:0] rdata;
        logic        ready;
        logic        slvErr;
        logic        irq;
    } psa_top_state_t;

    // state of the edge detector
    typedef struct packed {
        logic [7:0] prev;
        logic       armed;
    } psa_edge_state_t;

endpackage : psa_pkg

//--- psa_reset_sync.sv
// reset release synchroniser: asynchronous assertion, two-flop release
`timescale 1ns/1ns
module psa_reset_sync
    import psa_pkg::*;
(
    input  wire logic clock,
    input  wire logic reset_n,
    output logic      resetSync_n
);

    logic [1:0] stage_reg;
    logic [1:0] stage_next;

    // ------------------------------------------------------------------------
    // shift chain
    // ------------------------------------------------------------------------
    // first stage feeds only the second, so a late release cannot glitch logic
    always_comb begin
        stage_next = {stage_reg[0], 1'b1};
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stage_reg <= 2'b00;
        end else begin
            stage_reg <= stage_next;
        end
    end

    assign resetSync_n = stage_reg[1];

endmodule : psa_reset_sync

//--- psa_top.sv
// protection alarm event flags with APB register access and interrupt output
//
// How it works
// - bit 4 sets on enabled rising edge of switch byte failure.
// - bit 1 sets on any enabled edge of signal fail.
// - bit 0 sets on any enabled edge of signal degrade.
// - dual-event flags react to both rising and falling status edges.
// - single-event flags react to rising edges only.
// - a flag sets only while its enable bit is set.
// - reading the event register at index 0x42 clears its flags.
// - bits 7, 6, 5, 3 and 2 read as zero.
`timescale 1ns/1ns
`include "psa_defines.svh"
module psa_top
    import psa_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    input  wire logic              clock,
    input  wire logic              reset_n,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   irq,
    input  wire logic              switchByteFailure,
    input  wire logic              signalFail,
    input  wire logic              signalDegrade
);

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    psa_top_state_t s_reg;
    psa_top_state_t s_next;
    logic           resetSync_n;
    logic [7:0]     statusVec;
    logic [7:0]     eventVec;
    logic           armed;
    logic           setupPhase;
    logic           accessDone;
    logic           readClear;
    logic [7:0]     clearBits;
    psa_reg_sel_t   setupSel;
    psa_reg_sel_t   doneSel;

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    // word decode; misaligned or unlisted addresses map to nothing
    function automatic psa_reg_sel_t regDecode(input logic [ADDR_W-1:0] addr);
        psa_reg_sel_t sel;
        logic [ADDR_W-3:0] idx;
        sel = PSA_SEL_NONE;
        idx = addr[ADDR_W-1:2];
        if (addr[1:0] == 2'b00) begin
            if (idx == (ADDR_W-2)'(`PSA_IDX_FLAGS)) begin
                sel = PSA_SEL_FLAGS;
            end else if (idx == (ADDR_W-2)'(`PSA_IDX_ENABLE)) begin
                sel = PSA_SEL_ENABLE;
            end else if (idx == (ADDR_W-2)'(`PSA_IDX_MASK)) begin
                sel = PSA_SEL_MASK;
            end else if (idx == (ADDR_W-2)'(`PSA_IDX_LIVE)) begin
                sel = PSA_SEL_LIVE;
            end
        end
        return sel;
    endfunction : regDecode

    // ------------------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------------------
    psa_reset_sync u_reset_sync (
        .clock       (clock),
        .reset_n     (reset_n),
        .resetSync_n (resetSync_n)
    );

    // alarm sources gathered in register layout
    always_comb begin
        statusVec                    = 8'h00;
        statusVec[`PSA_BIT_SWBYTE]   = switchByteFailure;
        statusVec[`PSA_BIT_SIGFAIL]  = signalFail;
        statusVec[`PSA_BIT_SIGDEG]   = signalDegrade;
    end

    psa_event_detect #(
        .WIDTH     (8),
        .DUAL_MASK (`PSA_DUAL_MASK)
    ) u_event_detect (
        .clock       (clock),
        .resetSync_n (resetSync_n),
        .statusIn    (statusVec),
        .enableIn    (s_reg.enable),
        .eventOut    (eventVec),
        .armed       (armed)
    );

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    // zero wait state slave: data is captured in setup, ready in the access
    // cycle; the read clears only the bits it returned, so an event that lands
    // between capture and completion stays pending
    always_comb begin
        s_next     = s_reg;
        setupPhase = psel && !penable;
        accessDone = psel && penable && s_reg.ready;
        setupSel   = regDecode(paddr);
        doneSel    = setupSel;
        readClear  = accessDone && !pwrite && (doneSel == PSA_SEL_FLAGS);
        clearBits  = readClear ? s_reg.rdata[7:0] : 8'h00;

        // bus response
        s_next.ready = setupPhase;
        if (setupPhase) begin
            s_next.slvErr = (setupSel == PSA_SEL_NONE);
            unique case (setupSel)
                PSA_SEL_NONE:   s_next.rdata = `PSA_DATA_RESET;
                PSA_SEL_FLAGS:  s_next.rdata = 32'(s_reg.flags & `PSA_FLAG_MASK);
                PSA_SEL_ENABLE: s_next.rdata = 32'(s_reg.enable);
                PSA_SEL_MASK:   s_next.rdata = 32'(s_reg.mask);
                PSA_SEL_LIVE:   s_next.rdata = 32'(statusVec);
            endcase
        end

        // flags: set beats clear
        s_next.flags = ((s_reg.flags & ~clearBits) | eventVec) & `PSA_FLAG_MASK;

        // software writes; the event register itself ignores writes
        if (accessDone && pwrite) begin
            unique case (doneSel)
                PSA_SEL_ENABLE: s_next.enable = pwdata[7:0] & `PSA_FLAG_MASK;
                PSA_SEL_MASK:   s_next.mask   = pwdata[7:0] & `PSA_FLAG_MASK;
                PSA_SEL_NONE, PSA_SEL_FLAGS, PSA_SEL_LIVE: begin
                end
            endcase
        end

        // level interrupt from unmasked pending flags
        s_next.irq = |(s_next.flags & s_next.mask);
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge clock or negedge resetSync_n) begin
        if (!resetSync_n) begin
            s_reg.flags  <= `PSA_FLAGS_RESET;
            s_reg.enable <= `PSA_ENABLE_RESET;
            s_reg.mask   <= `PSA_MASK_RESET;
            s_reg.rdata  <= `PSA_DATA_RESET;
            s_reg.ready  <= 1'b0;
            s_reg.slvErr <= 1'b0;
            s_reg.irq    <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata  = s_reg.rdata;
    assign pready  = s_reg.ready;
    assign pslverr = s_reg.slvErr;
    assign irq     = s_reg.irq;

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetSync_n);

    byte_fail_rise_a: assert property (
        armed && s_reg.enable[`PSA_BIT_SWBYTE] && $rose(switchByteFailure) |=> s_reg.flags[`PSA_BIT_SWBYTE])
        else $error("switch byte failure rise did not set its flag");

    byte_fail_fall_a: assert property (
        !s_reg.flags[`PSA_BIT_SWBYTE] && !$rose(switchByteFailure) |=> !s_reg.flags[`PSA_BIT_SWBYTE])
        else $error("switch byte failure flag set without a rising edge");

    sig_fail_edge_a: assert property (
        armed && s_reg.enable[`PSA_BIT_SIGFAIL] && $changed(signalFail) |=> s_reg.flags[`PSA_BIT_SIGFAIL])
        else $error("signal fail edge did not set its flag");

    sig_degrade_fall_a: assert property (
        armed && s_reg.enable[`PSA_BIT_SIGDEG] && $fell(signalDegrade) |=> s_reg.flags[`PSA_BIT_SIGDEG])
        else $error("signal degrade falling edge did not set its flag");

    sig_degrade_rise_a: assert property (
        armed && s_reg.enable[`PSA_BIT_SIGDEG] && $rose(signalDegrade) |=> s_reg.flags[`PSA_BIT_SIGDEG])
        else $error("signal degrade rising edge did not set its flag");

    enable_gate_a: assert property (
        !s_reg.enable[`PSA_BIT_SIGFAIL] && !s_reg.flags[`PSA_BIT_SIGFAIL] |=> !s_reg.flags[`PSA_BIT_SIGFAIL])
        else $error("signal fail flag set while disabled");

    read_clear_a: assert property (
        readClear && (eventVec == 8'h00) |=> (s_reg.flags & $past(s_reg.rdata[7:0])) == 8'h00)
        else $error("read of event register did not clear returned flags");

    reserved_zero_a: assert property (
        setupPhase && (setupSel == PSA_SEL_FLAGS)
        |=> ((prdata[7:0] & ~`PSA_FLAG_MASK) == 8'h00) && (prdata[31:8] == 24'h00_0000))
        else $error("reserved event bits not zero");

    set_wins_a: assert property (
        readClear && (eventVec != 8'h00) |=> (s_reg.flags & $past(eventVec)) == $past(eventVec))
        else $error("event lost under a clearing read");

    irq_level_a: assert property (
        irq == |(s_reg.flags & s_reg.mask))
        else $error("interrupt output does not match unmasked flags");

    bus_ready_a: assert property (
        setupPhase |=> pready ##1 !pready)
        else $error("ready not given exactly in the access cycle");

    // event capture: no flag may appear without its enabled transition, and an enabled signal fail edge sets its flag
    reserved_flags_a: assert property (
        (s_reg.flags & ~`PSA_FLAG_MASK) == 8'h00)
        else $error("reserved event flag bit set");

    byte_fail_gate_a: assert property (
        !s_reg.enable[`PSA_BIT_SWBYTE] && !s_reg.flags[`PSA_BIT_SWBYTE] |=> !s_reg.flags[`PSA_BIT_SWBYTE])
        else $error("switch byte failure flag set while disabled");

    sig_degrade_gate_a: assert property (
        !s_reg.enable[`PSA_BIT_SIGDEG] && !s_reg.flags[`PSA_BIT_SIGDEG] |=> !s_reg.flags[`PSA_BIT_SIGDEG])
        else $error("signal degrade flag set while disabled");

    sig_fail_quiet_a: assert property (
        !s_reg.flags[`PSA_BIT_SIGFAIL] && !$changed(signalFail) |=> !s_reg.flags[`PSA_BIT_SIGFAIL])
        else $error("signal fail flag set without a status change");

    sig_degrade_quiet_a: assert property (
        !s_reg.flags[`PSA_BIT_SIGDEG] && !$changed(signalDegrade) |=> !s_reg.flags[`PSA_BIT_SIGDEG])
        else $error("signal degrade flag set without a status change");

    byte_fall_drop_a: assert property (
        $fell(switchByteFailure) && !s_reg.flags[`PSA_BIT_SWBYTE] |=> !s_reg.flags[`PSA_BIT_SWBYTE])
        else $error("switch byte failure falling edge set its flag");

    sig_fail_fall_a: assert property (
        armed && s_reg.enable[`PSA_BIT_SIGFAIL] && $fell(signalFail) |=> s_reg.flags[`PSA_BIT_SIGFAIL])
        else $error("signal fail falling edge did not set its flag");

    sig_fail_rise_a: assert property (
        armed && s_reg.enable[`PSA_BIT_SIGFAIL] && $rose(signalFail) |=> s_reg.flags[`PSA_BIT_SIGFAIL])
        else $error("signal fail rising edge did not set its flag");

    // clear on read: flags only fall through a completed read of the event register
    flags_sticky_a: assert property (
        !readClear |=> (s_reg.flags & $past(s_reg.flags)) == $past(s_reg.flags))
        else $error("event flag dropped without a clearing read");

    flag_write_drop_a: assert property (
        accessDone && pwrite && (doneSel == PSA_SEL_FLAGS) && (eventVec == 8'h00) |=> s_reg.flags == $past(s_reg.flags))
        else $error("write changed the event register");

    // register access: software owns enable and mask, the bus answers every setup
    enable_write_a: assert property (
        accessDone && pwrite && (doneSel == PSA_SEL_ENABLE)
        |=> s_reg.enable == ($past(pwdata[7:0]) & `PSA_FLAG_MASK))
        else $error("enable register write not taken");

    mask_write_a: assert property (
        accessDone && pwrite && (doneSel == PSA_SEL_MASK) |=> s_reg.mask == ($past(pwdata[7:0]) & `PSA_FLAG_MASK))
        else $error("mask register write not taken");

    enable_hold_a: assert property (
        !(accessDone && pwrite && (doneSel == PSA_SEL_ENABLE)) |=> $stable(s_reg.enable))
        else $error("enable register changed without a write");

    mask_hold_a: assert property (
        !(accessDone && pwrite && (doneSel == PSA_SEL_MASK)) |=> $stable(s_reg.mask))
        else $error("mask register changed without a write");

    flags_read_a: assert property (
        setupPhase && (setupSel == PSA_SEL_FLAGS) |=> prdata[7:0] == $past(s_reg.flags))
        else $error("event register read returned wrong flags");

    live_read_a: assert property (
        setupPhase && (setupSel == PSA_SEL_LIVE) |=> prdata == 32'($past(statusVec)))
        else $error("live status read returned wrong value");

    unmapped_error_a: assert property (
        setupPhase && (setupSel == PSA_SEL_NONE) |=> pslverr && (prdata == 32'h0000_0000))
        else $error("unmapped access not answered with an error");

    mapped_no_error_a: assert property (
        setupPhase && (setupSel != PSA_SEL_NONE) |=> !pslverr)
        else $error("mapped access answered with an error");

    // a ready without a setup would complete a transfer nobody started
    ready_idle_a: assert property (
        !psel |=> !pready)
        else $error("ready raised while the bus is idle");

endmodule : psa_top

//--- psa_top_tb_top.sv
// self-checking testbench of the protection alarm event block, with a behavioural flag model
`timescale 1ns/1ns
`include "psa_defines.svh"
module psa_top_tb_top;

    // ------------------------------------------------------------------------
    // constants, signals and model state
    // ------------------------------------------------------------------------
    localparam logic [11:0] FLG  = 12'({`PSA_IDX_FLAGS, 2'b00});
    localparam logic [11:0] ENA  = 12'({`PSA_IDX_ENABLE, 2'b00});
    localparam logic [11:0] MSK  = 12'({`PSA_IDX_MASK, 2'b00});
    localparam logic [11:0] LIV  = 12'({`PSA_IDX_LIVE, 2'b00});
    localparam logic [7:0]  LAY  = `PSA_FLAG_MASK;
    localparam logic [7:0]  DUAL = `PSA_DUAL_MASK;

    logic        clock;
    logic        reset_n;
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        switchByteFailure;
    logic        signalFail;
    logic        signalDegrade;
    logic [7:0]  mFlags;
    logic [7:0]  mEnable;
    logic [7:0]  mMask;
    logic [7:0]  mPrev;
    logic [31:0] rnd;
    int          bad_count;
    int          cmp_count;

    psa_top i_dut (
        .clock             (clock),
        .reset_n           (reset_n),
        .paddr             (paddr),
        .psel              (psel),
        .penable           (penable),
        .pwrite            (pwrite),
        .pwdata            (pwdata),
        .prdata            (prdata),
        .pready            (pready),
        .pslverr           (pslverr),
        .irq               (irq),
        .switchByteFailure (switchByteFailure),
        .signalFail        (signalFail),
        .signalDegrade     (signalDegrade)
    );

    // free-running 50 MHz clock
    always #10 clock = ~clock;

    // ------------------------------------------------------------------------
    // model and bus tasks
    // ------------------------------------------------------------------------
    // events of one status step: dual bits on any change, single bit on rising only
    function automatic logic [7:0] evf(input logic [7:0] p, input logic [7:0] c, input logic [7:0] e);
        return ((p ^ c) & DUAL & e) | (~p & c & LAY & ~DUAL & e);
    endfunction : evf

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // status pins in flag layout
    task automatic drive(input logic [7:0] s);
        switchByteFailure <= s[`PSA_BIT_SWBYTE];
        signalFail        <= s[`PSA_BIT_SIGFAIL];
        signalDegrade     <= s[`PSA_BIT_SIGDEG];
    endtask : drive

    // settle time covers the one-cycle flag latency with margin
    task automatic setStat(input logic [7:0] s);
        @(posedge clock);
        drive(s);
        mFlags |= evf(mPrev, s, mEnable);
        mPrev = s;
        repeat (3) @(posedge clock);
    endtask : setStat

    // one APB transfer; chg moves the status pins at the access edge, so the event meets the clearing read
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic chg,
                       input logic [7:0] s);
        logic [31:0] expd;
        logic        expe;
        int          n;
        expe = !(a inside {FLG, ENA, MSK, LIV});
        expd = 32'h0000_0000;
        if (!w && a == FLG) expd[7:0] = mFlags;
        if (!w && a == ENA) expd[7:0] = mEnable;
        if (!w && a == MSK) expd[7:0] = mMask;
        if (!w && a == LIV) expd[7:0] = mPrev;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        if (chg) drive(s);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) bad_count++;
        if (!w) check(prdata, expd);
        check(32'(pslverr), 32'(expe));
        psel    <= 1'b0;
        penable <= 1'b0;
        if (!w && a == FLG) mFlags = 8'h00;
        if (chg) mFlags |= evf(mPrev, s, mEnable);
        if (chg) mPrev = s;
        if (w && a == ENA) mEnable = d[7:0] & LAY;
        if (w && a == MSK) mMask = d[7:0] & LAY;
        // irq is registered on the same edge as the flags it reflects; two edges leave margin
        repeat (2) @(posedge clock);
        check(32'(irq), 32'((mFlags & mMask) != 8'h00));
    endtask : apb

    task automatic final_report;
        if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    // directed cases first, then random traffic over all registers and pins
    initial begin
        {clock, reset_n, psel, penable, pwrite, switchByteFailure, signalFail, signalDegrade} = '0;
        {paddr, pwdata, mFlags, mEnable, mMask, mPrev, bad_count, cmp_count} = '0;
        void'($urandom(64582));
        repeat (10) @(posedge clock);
        check({30'h0, pready, irq}, 32'h0000_0000);
        check(prdata, 32'h0000_0000);
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        repeat (6) @(posedge clock);
        apb(1'b0, FLG, 32'h0, 1'b0, 8'h00);
        apb(1'b0, ENA, 32'h0, 1'b0, 8'h00);
        apb(1'b0, MSK, 32'h0, 1'b0, 8'h00);
        apb(1'b1, ENA, 32'hFFFF_FFFF, 1'b0, 8'h00);
        apb(1'b1, MSK, 32'hFFFF_FFFF, 1'b0, 8'h00);
        apb(1'b0, ENA, 32'h0, 1'b0, 8'h00);
        apb(1'b0, MSK, 32'h0, 1'b0, 8'h00);
        apb(1'b1, FLG, 32'hFFFF_FFFF, 1'b0, 8'h00);
        apb(1'b0, FLG, 32'h0, 1'b0, 8'h00);
        apb(1'b0, 12'h200, 32'h0, 1'b0, 8'h00);
        apb(1'b0, 12'h109, 32'h0, 1'b0, 8'h00);
        setStat(8'h10);
        apb(1'b0, FLG, 32'h0, 1'b0, 8'h00);
        setStat(8'h00);
        apb(1'b0, FLG, 32'h0, 1'b0, 8'h00);
        setStat(8'h03);
        apb(1'b0, FLG, 32'h0, 1'b0, 8'h00);
        setStat(8'h00);
        apb(1'b0, FLG, 32'h0, 1'b0, 8'h00);
        setStat(8'h01);
        apb(1'b0, FLG, 32'h0, 1'b0, 8'h00);
        apb(1'b1, ENA, 32'h0, 1'b0, 8'h00);
        setStat(8'h13);
        apb(1'b0, FLG, 32'h0, 1'b0, 8'h00);
        apb(1'b0, LIV, 32'h0, 1'b0, 8'h00);
        apb(1'b1, ENA, 32'h13, 1'b0, 8'h00);
        setStat(8'h12);
        apb(1'b0, FLG, 32'h0, 1'b1, 8'h11);
        apb(1'b0, FLG, 32'h0, 1'b0, 8'h00);
        for (int i = 0; i < 80; i++) begin
            rnd = $urandom;
            case (rnd[2:0])
                3'd0: apb(1'b1, ENA, rnd, 1'b0, 8'h00);
                3'd1: apb(1'b1, MSK, rnd, 1'b0, 8'h00);
                3'd2: apb(1'b0, FLG, 32'h0, rnd[3], rnd[15:8] & LAY);
                3'd3: apb(1'b0, LIV, 32'h0, 1'b0, 8'h00);
                default: setStat(rnd[15:8] & LAY);
            endcase
        end
        apb(1'b0, FLG, 32'h0, 1'b0, 8'h00);
        final_report();
    end

    // watchdog well beyond the expected run of about 530 cycles
    initial begin
        #(20 * 5000);
        bad_count++;
        final_report();
    end

endmodule : psa_top_tb_top
